// ==== core/cad_pkg.sv ====
// Package of address map constants and carrier types for the processor address decoder
package cad_pkg;
   // Processor map boundaries
   localparam logic [31:0] CAD_DRAM_END = 32'h7fffffff;
   localparam logic [31:0] CAD_ISAIO_BASE = 32'h80000000;
   localparam logic [31:0] CAD_ISAIO_END = 32'h807fffff;
   localparam logic [31:0] CAD_CFG_BASE = 32'h80800000;
   localparam logic [31:0] CAD_CFG_END = 32'h80ffffff;
   localparam logic [31:0] CAD_PIO_BASE = 32'h81000000;
   localparam logic [31:0] CAD_PIO_END = 32'hbf7fffff;
   localparam logic [31:0] CAD_IACK_BASE = 32'hbffffff0;
   localparam logic [31:0] CAD_MEM_BASE = 32'hc0000000;
   localparam logic [31:0] CAD_MEM_END = 32'hfeffffff;
   localparam logic [31:0] CAD_FLASH_BASE = 32'hff000000;
   // Translation: PCI address keeps the low 30 bits
   localparam logic [31:0] CAD_PCI_MASK = 32'h3fffffff;
   // Flash decode: 1MB repeat, bank bit splits 512KB halves
   localparam int CAD_FLASH_WRAP_BITS = 20;
   localparam int CAD_FLASH_BANK_BIT = 19;
   // ISA I/O discontiguous packing: 32-byte blocks on 4KB pages
   localparam int CAD_BLK_BITS = 5;
   localparam int CAD_PAGE_BITS = 12;
   // Config space: 256-byte functions, IDSEL from A11..A16
   localparam int CAD_IDSEL_LO = 11;
   localparam int CAD_IDSEL_N = 6;
   localparam logic [7:0] CAD_CFG_FN_MASK = 8'hff;
   // Indirect configuration ports
   localparam logic [15:0] CAD_CFG_ADDR_PORT = 16'h0cf8;
   localparam logic [15:0] CAD_CFG_DATA_PORT = 16'h0cfc;
   // Named ISA I/O functions
   localparam logic [15:0] CAD_RTC_ADDR0 = 16'h0074;
   localparam logic [15:0] CAD_RTC_ADDR1 = 16'h0075;
   localparam logic [15:0] CAD_RTC_DATA = 16'h0077;
   localparam logic [15:0] CAD_SCC_B_CTL = 16'h0840;

   typedef enum logic [7:0] {
      CAD_R_NONE = 8'h01,
      CAD_R_DRAM = 8'h02,
      CAD_R_ISAIO = 8'h04,
      CAD_R_CFG = 8'h08,
      CAD_R_PIO = 8'h10,
      CAD_R_IACK = 8'h20,
      CAD_R_MEM = 8'h40,
      CAD_R_FLASH = 8'h80
   } cad_region_t;

   typedef enum logic [3:0] {
      CAD_F_NONE = 4'h1,
      CAD_F_RTC = 4'h2,
      CAD_F_SCC_B_CTL = 4'h4,
      CAD_F_CFG_PORT = 4'h8
   } cad_func_t;

   typedef struct packed {
      cad_region_t region;
      logic [31:0] pci_addr;
      logic [CAD_IDSEL_N-1:0] idsel;
      logic flash_bank;
      logic [19:0] flash_off;
      logic [15:0] isa_addr;
      cad_func_t func;
      logic valid;
   } cad_dec_t;

   typedef struct packed {
      cad_dec_t dec;
   } cad_state_t;
endpackage : cad_pkg

// ==== core/cad_decoder.sv ====
// Processor address decoder and PCI/ISA address translator
`timescale 1ns/100ps
// Summary of operation
// - Addresses up to 7FFFFFFF go to local DRAM, never to PCI.
// - 80800000 8M range is direct configuration space, PCI 00800000 upward.
// - Indirect configuration through ports CF8 address and CFC data.
// - Window 80000000-807FFFFF reaches ISA/PCI I/O, contiguous or discontiguous.
// - ISA 0074 sits at 80003014 discontiguous, 80000074 contiguous.
// - Flash ignores address bits above 1MB, repeating across the top 16MB.
// - Lower 512KB of each megabyte is flash bank 0, upper is bank 1.
// - Config at 80800800 asserts ISA bridge IDSEL from A11, 256 bytes.
// - Config at 80810000 asserts mezzanine slot IDSEL from A16.
// - Unassigned ISA I/O locations are reserved and claim no function.
// - Serial channel B control at ISA 0840, 80042000 discontiguous.
// - Real-time clock and NVRAM reachable at its strobe and data ports.
module cad_decoder
   import cad_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Processor request
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   // Mapping mode, high selects discontiguous ISA I/O
   input wire logic discontig_i,
   // Decoded result, one cycle after the request
   output logic dec_valid_o,
   output cad_region_t region_o,
   output logic [31:0] pci_addr_o,
   output logic [CAD_IDSEL_N-1:0] idsel_o,
   output logic flash_bank_o,
   output logic [19:0] flash_off_o,
   output logic [15:0] isa_addr_o,
   output cad_func_t func_o
);

   cad_state_t st_ff;
   cad_state_t nxt_st;

   // Window offset to ISA I/O address under either mapping
   function automatic logic [15:0] isa_from_win(input logic [22:0] off, input logic dis);
      logic [15:0] a;
      a = off[15:0];
      if (dis) begin
         a = {off[22:CAD_PAGE_BITS], off[CAD_BLK_BITS-1:0]};
      end
      return a;
   endfunction : isa_from_win

   function automatic cad_func_t isa_func(input logic [15:0] a);
      cad_func_t f;
      f = CAD_F_NONE;
      if (a == CAD_RTC_ADDR0 || a == CAD_RTC_ADDR1 || a == CAD_RTC_DATA) begin
         f = CAD_F_RTC;
      end else if (a == CAD_SCC_B_CTL) begin
         f = CAD_F_SCC_B_CTL;
      end else if (a[15:2] == CAD_CFG_ADDR_PORT[15:2] || a[15:2] == CAD_CFG_DATA_PORT[15:2]) begin
         f = CAD_F_CFG_PORT;
      end
      return f;
   endfunction : isa_func

   // Parameter sanity: packing must fill 16 ISA bits, bank bit must sit in the offset
   if (23 - CAD_PAGE_BITS + CAD_BLK_BITS != 16) begin : g_chk_pack
      $error("Discontiguous packing does not give 16 bits");
   end
   if (CAD_FLASH_WRAP_BITS != 20) begin : g_chk_wrap
      $error("Flash offset port width does not match the wrap size");
   end
   if (CAD_FLASH_BANK_BIT != CAD_FLASH_WRAP_BITS - 1) begin : g_chk_bank
      $error("Flash bank bit outside the wrapped offset");
   end
   if (CAD_IDSEL_LO + CAD_IDSEL_N > 23) begin : g_chk_idsel
      $error("IDSEL lines reach outside configuration space");
   end

   always_comb begin
      logic [15:0] isa;
      isa = isa_from_win(addr_i[22:0], discontig_i);
      nxt_st = st_ff;
      nxt_st.dec.valid = req_i;
      if (req_i) begin
         nxt_st.dec.pci_addr = addr_i & CAD_PCI_MASK;
         nxt_st.dec.idsel = '0;
         nxt_st.dec.flash_bank = 1'b0;
         nxt_st.dec.flash_off = '0;
         nxt_st.dec.isa_addr = '0;
         nxt_st.dec.func = CAD_F_NONE;
         if (addr_i <= CAD_DRAM_END) begin
            nxt_st.dec.region = CAD_R_DRAM;
            nxt_st.dec.pci_addr = '0;
         end else if (addr_i <= CAD_ISAIO_END) begin
            nxt_st.dec.region = CAD_R_ISAIO;
            nxt_st.dec.pci_addr = {16'h0000, isa};
            nxt_st.dec.isa_addr = isa;
            nxt_st.dec.func = isa_func(isa);
         end else if (addr_i <= CAD_CFG_END) begin
            nxt_st.dec.region = CAD_R_CFG;
            nxt_st.dec.idsel = addr_i[CAD_IDSEL_LO +: CAD_IDSEL_N];
         end else if (addr_i <= CAD_PIO_END) begin
            nxt_st.dec.region = CAD_R_PIO;
         end else if (addr_i >= CAD_IACK_BASE && addr_i < CAD_MEM_BASE) begin
            nxt_st.dec.region = CAD_R_IACK;
         end else if (addr_i >= CAD_MEM_BASE && addr_i <= CAD_MEM_END) begin
            nxt_st.dec.region = CAD_R_MEM;
         end else if (addr_i >= CAD_FLASH_BASE) begin
            nxt_st.dec.region = CAD_R_FLASH;
            nxt_st.dec.pci_addr = '0;
            nxt_st.dec.flash_off = addr_i[CAD_FLASH_WRAP_BITS-1:0];
            nxt_st.dec.flash_bank = addr_i[CAD_FLASH_BANK_BIT];
         end else begin
            nxt_st.dec.region = CAD_R_NONE;
            nxt_st.dec.pci_addr = '0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         st_ff <= '{dec: '{region: CAD_R_NONE, func: CAD_F_NONE, default: '0}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dec_valid_o = st_ff.dec.valid;
   assign region_o = st_ff.dec.region;
   assign pci_addr_o = st_ff.dec.pci_addr;
   assign idsel_o = st_ff.dec.idsel;
   assign flash_bank_o = st_ff.dec.flash_bank;
   assign flash_off_o = st_ff.dec.flash_off;
   assign isa_addr_o = st_ff.dec.isa_addr;
   assign func_o = st_ff.dec.func;

   chk_dram_not_pci: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i <= CAD_DRAM_END |=> region_o == CAD_R_DRAM && pci_addr_o == 32'h0)
      else $error("DRAM access forwarded");
   chk_cfg_translate: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_CFG_BASE && addr_i <= CAD_CFG_END
      |=> region_o == CAD_R_CFG && pci_addr_o == $past(addr_i) - 32'h80000000)
      else $error("Config translation wrong");
   chk_cfg_ports: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000cf8 |=> func_o == CAD_F_CFG_PORT)
      else $error("Config port not decoded");
   chk_isa_window: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_ISAIO_BASE && addr_i <= CAD_ISAIO_END |=> region_o == CAD_R_ISAIO)
      else $error("ISA window missed");
   chk_rtc_discontig: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i == 32'h80003014
      |=> isa_addr_o == CAD_RTC_ADDR0 && func_o == CAD_F_RTC)
      else $error("RTC strobe discontiguous wrong");
   chk_rtc_contig: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000077 |=> func_o == CAD_F_RTC)
      else $error("RTC data port wrong");
   chk_flash_wrap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_FLASH_BASE |=> region_o == CAD_R_FLASH
      && flash_off_o == $past(addr_i[19:0]))
      else $error("Flash wrap wrong");
   chk_flash_bank: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i == 32'hff080000 |=> flash_bank_o && flash_off_o == 20'h80000)
      else $error("Flash bank 1 not selected");
   chk_bridge_idsel: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i[31:8] == 24'h808008 |=> idsel_o == 6'h01)
      else $error("Bridge IDSEL wrong");
   chk_slot_idsel: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i[31:8] == 24'h808100 |=> idsel_o == 6'h20)
      else $error("Slot IDSEL wrong");
   chk_scc_ctl: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i == 32'h80042000 |=> func_o == CAD_F_SCC_B_CTL)
      else $error("Serial B control wrong");
   chk_reserved_io: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000500 |=> func_o == CAD_F_NONE)
      else $error("Reserved I/O claimed");
   chk_discontig_pack: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i[31:23] == 9'h100
      |=> isa_addr_o == {$past(addr_i[22:12]), $past(addr_i[4:0])})
      else $error("Discontiguous packing wrong");
   chk_contig_pack: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i[31:23] == 9'h100
      |=> isa_addr_o == $past(addr_i[15:0]))
      else $error("Contiguous mapping wrong");
   chk_isa_pci_addr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i[31:23] == 9'h100 |=> pci_addr_o == {16'h0000, isa_addr_o})
      else $error("ISA window PCI address wrong");
   chk_cfg_data_port: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000cfc |=> func_o == CAD_F_CFG_PORT)
      else $error("Config data port not decoded");
   chk_rtc_contig_strobe: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000074
      |=> isa_addr_o == CAD_RTC_ADDR0 && func_o == CAD_F_RTC)
      else $error("RTC strobe contiguous wrong");
   chk_rtc_strobe_one: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i == 32'h80003015 |=> func_o == CAD_F_RTC)
      else $error("RTC second strobe wrong");
   chk_flash_bank0: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_FLASH_BASE && !addr_i[19] |=> !flash_bank_o)
      else $error("Flash bank 0 not selected");
   chk_flash_local: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_FLASH_BASE |=> pci_addr_o == 32'h0)
      else $error("Flash access forwarded");
   chk_cfg_idsel_raw: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && addr_i >= CAD_CFG_BASE && addr_i <= CAD_CFG_END
      |=> idsel_o == $past(addr_i[16:11]))
      else $error("IDSEL lines wrong");
   chk_idsel_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !(addr_i >= CAD_CFG_BASE && addr_i <= CAD_CFG_END)
      |=> idsel_o == 6'h00)
      else $error("IDSEL outside config space");
   chk_scc_contig: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && !discontig_i && addr_i == 32'h80000840 |=> func_o == CAD_F_SCC_B_CTL)
      else $error("Serial B control contiguous wrong");
   chk_reserved_page: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i == 32'h80003018 |=> func_o == CAD_F_NONE)
      else $error("Reserved discontiguous I/O claimed");

   cov_dram: cover property (@(posedge mclk_i) disable iff (!nrst_i) region_o == CAD_R_DRAM);
   cov_cfg: cover property (@(posedge mclk_i) disable iff (!nrst_i) region_o == CAD_R_CFG);
   cov_isa_dis: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      req_i && discontig_i && addr_i[31:23] == 9'h100);
   cov_flash1: cover property (@(posedge mclk_i) disable iff (!nrst_i) flash_bank_o);
   cov_pci_io: cover property (@(posedge mclk_i) disable iff (!nrst_i) region_o == CAD_R_PIO);
endmodule : cad_decoder

// ==== dv/cad_cpu_model.sv ====
// Processor bus master model that issues decode requests
`timescale 1ns/100ps
module cad_cpu_model (
   // Clock
   input wire logic mclk_i,
   // Request to the decoder
   output logic req_o,
   output logic [31:0] addr_o
);
   initial begin
      req_o = 1'b0;
      addr_o = 32'h0;
   end
   // Called just after an edge; keep holds req up for a back-to-back follower
   // Callers stay clear of config gaps and the middle flash megabytes
   task automatic issue(input logic [31:0] a, input logic keep);
      req_o = 1'b1;
      addr_o = a;
      @(posedge mclk_i);
      #1;
      if (!keep) begin
         req_o = 1'b0;
         addr_o = ~a;
      end
   endtask : issue
endmodule : cad_cpu_model

// ==== dv/cpu_address_decoder_tb.sv ====
// Self-checking testbench for the processor address decoder
`timescale 1ns/100ps
module cpu_address_decoder_tb;
   import cad_pkg::*;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic discontig_i = 1'b0;
   logic req;
   logic [31:0] addr;
   logic dec_valid_o;
   cad_region_t region_o;
   logic [31:0] pci_addr_o;
   logic [CAD_IDSEL_N-1:0] idsel_o;
   logic flash_bank_o;
   logic [19:0] flash_off_o;
   logic [15:0] isa_addr_o;
   cad_func_t func_o;
   int errors = 0;
   int checked = 0;
   always #12.5 mclk_i = ~mclk_i;
   cad_cpu_model cpu (.mclk_i(mclk_i), .req_o(req), .addr_o(addr));
   cad_decoder uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req), .addr_i(addr),
      .discontig_i(discontig_i), .dec_valid_o(dec_valid_o), .region_o(region_o),
      .pci_addr_o(pci_addr_o), .idsel_o(idsel_o), .flash_bank_o(flash_bank_o),
      .flash_off_o(flash_off_o), .isa_addr_o(isa_addr_o), .func_o(func_o));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // One request, then the common fields one cycle later
   task automatic look(input logic [31:0] a, input logic d, input logic [7:0] rg,
         input logic [31:0] pa, input logic [15:0] ia, input logic [3:0] fn);
      discontig_i = d;
      cpu.issue(a, 1'b0);
      chk(dec_valid_o, 32'h1);
      chk(region_o, rg);
      chk(pci_addr_o, pa);
      if (rg == CAD_R_ISAIO) begin
         chk(isa_addr_o, ia);
         chk(func_o, fn);
      end
      // Idle edge so the next request is not raised where this one fell
      @(posedge mclk_i);
      #1;
      chk(dec_valid_o, 32'h0);
   endtask : look
   task automatic t_dram;
      chk(region_o, CAD_R_NONE);
      chk(func_o, CAD_F_NONE);
      look(32'h0, 1'b0, CAD_R_DRAM, 32'h0, 16'h0, CAD_F_NONE);
      look(32'h7fffffff, 1'b1, CAD_R_DRAM, 32'h0, 16'h0, CAD_F_NONE);
      look(32'h80000000, 1'b0, CAD_R_ISAIO, 32'h0, 16'h0, CAD_F_NONE);
      $display("t_dram done");
   endtask : t_dram
   task automatic t_isa;
      look(32'h80003014, 1'b1, CAD_R_ISAIO, 32'h74, 16'h74, CAD_F_RTC);
      look(32'h80000074, 1'b0, CAD_R_ISAIO, 32'h74, 16'h74, CAD_F_RTC);
      look(32'h80003017, 1'b1, CAD_R_ISAIO, 32'h77, 16'h77, CAD_F_RTC);
      look(32'h80042000, 1'b1, CAD_R_ISAIO, 32'h840, 16'h840, CAD_F_SCC_B_CTL);
      look(32'h80000840, 1'b0, CAD_R_ISAIO, 32'h840, 16'h840, CAD_F_SCC_B_CTL);
      look(32'h80000cf8, 1'b0, CAD_R_ISAIO, 32'hcf8, 16'hcf8, CAD_F_CFG_PORT);
      look(32'h80000cfc, 1'b0, CAD_R_ISAIO, 32'hcfc, 16'hcfc, CAD_F_CFG_PORT);
      look(32'h80000805, 1'b0, CAD_R_ISAIO, 32'h805, 16'h805, CAD_F_NONE);
      look(32'h80003018, 1'b1, CAD_R_ISAIO, 32'h78, 16'h78, CAD_F_NONE);
      $display("t_isa done");
   endtask : t_isa
   task automatic t_cfg;
      look(32'h80800800, 1'b0, CAD_R_CFG, 32'h00800800, 16'h0, CAD_F_NONE);
      chk(idsel_o, 32'h01);
      look(32'h808008ff, 1'b0, CAD_R_CFG, 32'h008008ff, 16'h0, CAD_F_NONE);
      chk(idsel_o, 32'h01);
      look(32'h80810000, 1'b0, CAD_R_CFG, 32'h00810000, 16'h0, CAD_F_NONE);
      chk(idsel_o, 32'h20);
      $display("t_cfg done");
   endtask : t_cfg
   task automatic t_flash;
      look(32'hff080000, 1'b0, CAD_R_FLASH, 32'h0, 16'h0, CAD_F_NONE);
      chk(flash_bank_o, 32'h1);
      chk(flash_off_o, 32'h80000);
      look(32'hff07ffff, 1'b0, CAD_R_FLASH, 32'h0, 16'h0, CAD_F_NONE);
      chk(flash_bank_o, 32'h0);
      look(32'hfff80004, 1'b0, CAD_R_FLASH, 32'h0, 16'h0, CAD_F_NONE);
      chk(flash_bank_o, 32'h1);
      chk(flash_off_o, 32'h80004);
      $display("t_flash done");
   endtask : t_flash
   // Requests on consecutive edges, then the last answer must stand
   task automatic t_b2b;
      discontig_i = 1'b1;
      cpu.issue(32'h80003015, 1'b1);
      chk(isa_addr_o, 32'h75);
      chk(func_o, CAD_F_RTC);
      cpu.issue(32'h80810004, 1'b0);
      chk(dec_valid_o, 32'h1);
      chk(idsel_o, 32'h20);
      @(posedge mclk_i);
      #1;
      chk(dec_valid_o, 32'h0);
      chk(pci_addr_o, 32'h00810004);
      $display("t_b2b done");
   endtask : t_b2b
   // Two remaining regions, then a reset in mid-run and a request right after it, then the last two
   task automatic t_misc;
      look(32'h81000000, 1'b0, CAD_R_PIO, 32'h01000000, 16'h0, CAD_F_NONE);
      look(32'hbffffff0, 1'b0, CAD_R_IACK, 32'h3ffffff0, 16'h0, CAD_F_NONE);
      nrst_i = 1'b0;
      @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      chk(dec_valid_o, 32'h0);
      chk(region_o, CAD_R_NONE);
      chk(pci_addr_o, 32'h0);
      chk(func_o, CAD_F_NONE);
      look(32'h80003014, 1'b1, CAD_R_ISAIO, 32'h74, 16'h74, CAD_F_RTC);
      look(32'hc0000000, 1'b0, CAD_R_MEM, 32'h0, 16'h0, CAD_F_NONE);
      look(32'hbf800000, 1'b0, CAD_R_NONE, 32'h0, 16'h0, CAD_F_NONE);
      $display("t_misc done");
   endtask : t_misc
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (12) @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      t_dram;
      t_isa;
      t_cfg;
      t_flash;
      t_b2b;
      t_misc;
      wrap_up;
   end
   // The tests need well under a hundred cycles
   initial begin
      repeat (2000) @(posedge mclk_i);
      errors++;
      wrap_up;
   end
endmodule : cpu_address_decoder_tb
